/* File: pbs_sequencer.v */
`timescale 1ns/10ps
`include "pbs_map.vh"
module pbs_sequencer #(
   parameter EN_ACTIVE_HIGH = 1,
   parameter TICK_DIV = `PBS_TICK_DIV,
   parameter ON_DB_TICKS = `PBS_ON_DB_MS,
   parameter BLANK_TICKS = `PBS_BLANK_MS,
   parameter REL_DB_TICKS = `PBS_REL_DB_MS,
   parameter OFF_DB_TICKS = `PBS_OFF_DB_MS,
   parameter KILL_TICKS = `PBS_KILL_MS,
   parameter LOCK_TICKS = `PBS_LOCK_MS,
   parameter GLITCH_CYC = `PBS_GLITCH_CYC
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_button_n,
   input wire i_shutdown_req_n,
   input wire [15:0] i_off_debounce_extension,
   input wire [15:0] i_shutdown_timeout_extension,
   output reg o_supply_en,
   output reg o_power_down_alert_n
);
   localparam W = `PBS_CNT_W;
   localparam [6:0] S_OFF = 7'h01;
   localparam [6:0] S_BLANK = 7'h02;
   localparam [6:0] S_RELDB = 7'h04;
   localparam [6:0] S_RUN = 7'h08;
   localparam [6:0] S_KILLW = 7'h10;
   localparam [6:0] S_LOCK = 7'h20;
   localparam [6:0] S_OFFDB = 7'h40;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function [W-1:0] ticks;
      input integer n;
      begin
         ticks = n[W-1:0];
      end
   endfunction

   // base interval plus a user extension
   function [W-1:0] ext_ticks;
      input integer base;
      input [15:0] ext;
      begin
         ext_ticks = ticks(base) + ext;
      end
   endfunction

   // enable pin level for the built polarity
   function en_level;
      input active;
      begin
         en_level = (EN_ACTIVE_HIGH != 0) ? active : !active;
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   reg [2:0] btn_sync_r;
   reg [2:0] sd_sync_r;
   reg btn_r;
   reg sd_r;
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         btn_sync_r <= 3'h7;
         sd_sync_r <= 3'h0;
         btn_r <= 1'b1;
         sd_r <= 1'b0;
      end
      else
      begin
         btn_sync_r <= {btn_sync_r[1:0], i_button_n};
         sd_sync_r <= {sd_sync_r[1:0], i_shutdown_req_n};
         if (btn_sync_r[1] == btn_sync_r[2])
            btn_r <= btn_sync_r[2];
         if (sd_sync_r[1] == sd_sync_r[2])
            sd_r <= sd_sync_r[2];
      end
   end

   // ------------------------------------------------------------
   // shutdown glitch filter
   // ------------------------------------------------------------
   reg [15:0] glitch_r;
   reg sd_low_r;
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         glitch_r <= 16'h0000;
         sd_low_r <= 1'b0;
      end
      else if (sd_r)
      begin
         glitch_r <= 16'h0000;
         sd_low_r <= 1'b0;
      end
      else if (glitch_r < GLITCH_CYC[15:0] - 16'h0001)
         glitch_r <= glitch_r + 16'h0001;
      else
         sd_low_r <= 1'b1;
   end

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   reg [15:0] div_r;
   reg tick_r;
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         div_r <= 16'h0000;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= (div_r == TICK_DIV[15:0] - 16'h0001);
         if (div_r == TICK_DIV[15:0] - 16'h0001)
            div_r <= 16'h0000;
         else
            div_r <= div_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   reg [6:0] state_r;
   reg [6:0] state_nxt;
   reg load;
   reg [W-1:0] load_val;
   reg en_nxt;
   reg alert_nxt;
   wire done;
   reg en_act_r;

   pbs_timer #(.W(W)) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_load(load),
      .i_count(load_val),
      .i_tick(tick_r),
      .o_done(done)
   );

   // ------------------------------------------------------------
   // state decode
   // ------------------------------------------------------------
   always @*
   begin
      state_nxt = state_r;
      load = 1'b0;
      load_val = {W{1'b0}};
      en_nxt = en_act_r;
      alert_nxt = o_power_down_alert_n;
      case (state_r)
         S_OFF:
         begin
            if (btn_r)
            begin
               load = 1'b1;
               load_val = ticks(ON_DB_TICKS);
            end
            else if (done)
            begin
               state_nxt = S_BLANK;
               en_nxt = 1'b1;
               load = 1'b1;
               load_val = ticks(BLANK_TICKS);
            end
         end
         S_BLANK:
         begin
            if (done)
            begin
               if (sd_low_r)
               begin
                  state_nxt = S_LOCK;
                  en_nxt = 1'b0;
                  load = 1'b1;
                  load_val = ticks(LOCK_TICKS);
               end
               else
               begin
                  state_nxt = S_RELDB;
                  load = 1'b1;
                  load_val = ticks(REL_DB_TICKS);
               end
            end
         end
         S_RELDB, S_RUN, S_OFFDB:
         begin
            if (sd_low_r)
            begin
               state_nxt = S_LOCK;
               en_nxt = 1'b0;
               load = 1'b1;
               load_val = ticks(LOCK_TICKS);
            end
            else if (state_r == S_RELDB)
            begin
               if (!btn_r)
               begin
                  load = 1'b1;
                  load_val = ticks(REL_DB_TICKS);
               end
               else if (done)
                  state_nxt = S_RUN;
            end
            else if (btn_r)
            begin
               state_nxt = S_RUN;
            end
            else if (state_r == S_RUN)
            begin
               state_nxt = S_OFFDB;
               load = 1'b1;
               load_val = ext_ticks(OFF_DB_TICKS, i_off_debounce_extension);
            end
            else if (done)
            begin
               state_nxt = S_KILLW;
               alert_nxt = 1'b0;
               load = 1'b1;
               load_val = ext_ticks(KILL_TICKS, i_shutdown_timeout_extension);
            end
         end
         S_KILLW:
         begin
            if (sd_low_r || done)
            begin
               state_nxt = S_LOCK;
               en_nxt = 1'b0;
               load = 1'b1;
               load_val = ticks(LOCK_TICKS);
            end
         end
         S_LOCK:
         begin
            alert_nxt = 1'b1;
            if (done)
            begin
               state_nxt = S_OFF;
               load = 1'b1;
               load_val = ticks(ON_DB_TICKS);
            end
         end
         default:
         begin
            state_nxt = S_OFF;
            en_nxt = 1'b0;
            alert_nxt = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_r <= S_OFF;
         en_act_r <= 1'b0;
         o_supply_en <= en_level(1'b0);
         o_power_down_alert_n <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         en_act_r <= en_nxt;
         o_supply_en <= en_level(en_nxt);
         o_power_down_alert_n <= alert_nxt;
      end
   end
endmodule // pbs_sequencer

/* File: pbs_map.vh */
`ifndef PBS_MAP_VH
`define PBS_MAP_VH
// ------------------------------------------------------------
// timing figures
// ------------------------------------------------------------
`define PBS_CLK_HZ 20000000
`define PBS_TICK_US 1000
`define PBS_TICK_DIV ((`PBS_CLK_HZ / 1000000) * `PBS_TICK_US)
`define PBS_ON_DB_MS 128
`define PBS_BLANK_MS 512
`define PBS_REL_DB_MS 32
`define PBS_OFF_DB_MS 32
`define PBS_KILL_MS 128
`define PBS_LOCK_MS 256
`define PBS_GLITCH_US 30
`define PBS_GLITCH_CYC ((`PBS_GLITCH_US * `PBS_CLK_HZ + 999999) / 1000000)
`define PBS_CNT_W 16
`endif

/* File: pbs_timer.v */
`timescale 1ns/10ps
// ------------------------------------------------------------
// tick-based down counter
// ------------------------------------------------------------
module pbs_timer #(
   parameter W = 16
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_load,
   input wire [W-1:0] i_count,
   input wire i_tick,
   output wire o_done
);
   reg [W-1:0] cnt_r;
   reg run_r;
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt_r <= {W{1'b0}};
         run_r <= 1'b0;
      end
      else if (i_load)
      begin
         cnt_r <= i_count;
         run_r <= 1'b1;
      end
      else if (run_r && i_tick && cnt_r != {W{1'b0}})
      begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign o_done = run_r && (cnt_r == {W{1'b0}});
endmodule // pbs_timer

/* File: pbs_sequencer_sva.sv */
`timescale 1ns/10ps
// ----
// checker
// ----
module pbs_sequencer_sva #(
   parameter EN_ACTIVE_HIGH = 1
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_button_n,
   input wire i_shutdown_req_n,
   input wire [15:0] i_off_debounce_extension,
   input wire [15:0] i_shutdown_timeout_extension,
   input wire o_supply_en,
   input wire o_power_down_alert_n
);
   wire on = o_supply_en == (EN_ACTIVE_HIGH != 0);
   wire al = o_power_down_alert_n;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   rst_off_a: assert property ($rose(i_arst_n) |-> !on && al)
      else $error("enable or alert wrong after reset");
   on_press_a: assert property ($rose(on) |-> !$past(i_button_n, 6) && !$past(i_button_n, 12))
      else $error("enable without held press");
   blank_hold_a: assert property ($rose(on) |-> on[*8])
      else $error("enable dropped in blanking");
   alert_on_a: assert property ($fell(al) |-> on && !$past(i_button_n, 6))
      else $error("alert without press");
   alert_wait_a: assert property ($fell(al) && i_shutdown_req_n |-> on[*6])
      else $error("enable dropped early");
   kill_bound_a: assert property ($fell(al) |-> ##[1:60] !on)
      else $error("no release after timeout");
   req_release_a: assert property ((!al && !i_shutdown_req_n)[*3] |-> ##[0:12] !on)
      else $error("request did not release");
   alert_back_a: assert property ($fell(on) |=> al)
      else $error("alert not back high");
   lock_hold_a: assert property ($fell(on) |-> !on[*8])
      else $error("enable during lockout");
endmodule // pbs_sequencer_sva
bind pbs_sequencer pbs_sequencer_sva #(.EN_ACTIVE_HIGH(EN_ACTIVE_HIGH)) u_sva (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_button_n(i_button_n),
   .i_shutdown_req_n(i_shutdown_req_n), .i_off_debounce_extension(i_off_debounce_extension),
   .i_shutdown_timeout_extension(i_shutdown_timeout_extension),
   .o_supply_en(o_supply_en), .o_power_down_alert_n(o_power_down_alert_n));

/* File: pbs_host_model.sv */
`timescale 1ns/10ps
// ----
// processor model
// ----
module pbs_host_model (
   input wire i_clk_sys,
   input wire i_on,
   input wire i_alert_n,
   input wire i_hang_boot,
   input wire i_hang_down,
   output wire o_shutdown_req_n
);
   reg [1:0] up_r = 2'h0;
   reg [1:0] dn_r = 2'h0;
   always @(posedge i_clk_sys)
   begin
      up_r <= !i_on ? 2'h0 : (up_r == 2'h3) ? up_r : up_r + 2'h1;
      dn_r <= i_alert_n ? 2'h0 : (dn_r == 2'h3) ? dn_r : dn_r + 2'h1;
   end
   // raise after boot, low when done or boot hung
   assign o_shutdown_req_n = up_r == 2'h3 && !i_hang_boot && !(dn_r == 2'h3 && !i_hang_down);
endmodule // pbs_host_model

/* File: pbs_sequencer_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module pbs_sequencer_tb;
   reg clk = 0;
   reg arst_n = 0;
   reg button_n = 1;
   reg hang_boot = 0;
   reg hang_down = 0;
   reg [15:0] kill_ext = 16'h0000;
   reg [15:0] off_ext = 16'h0001;
   wire en, en_b, alert_n, alert_b, req_n;
   int fails = 0;
   int total_checks = 0;
   int n;
   initial forever #25 clk = ~clk;
   pbs_host_model HOST (.i_clk_sys(clk), .i_on(en), .i_alert_n(alert_n),
      .i_hang_boot(hang_boot), .i_hang_down(hang_down), .o_shutdown_req_n(req_n));
   pbs_sequencer #(.TICK_DIV(4), .ON_DB_TICKS(4), .BLANK_TICKS(8), .REL_DB_TICKS(2),
      .OFF_DB_TICKS(3), .KILL_TICKS(4), .LOCK_TICKS(5), .GLITCH_CYC(3)) DUT (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_button_n(button_n), .i_shutdown_req_n(req_n),
      .i_off_debounce_extension(off_ext), .i_shutdown_timeout_extension(kill_ext),
      .o_supply_en(en), .o_power_down_alert_n(alert_n));
   pbs_sequencer #(.EN_ACTIVE_HIGH(0), .TICK_DIV(4), .ON_DB_TICKS(4), .BLANK_TICKS(8),
      .REL_DB_TICKS(2), .OFF_DB_TICKS(3), .KILL_TICKS(4), .LOCK_TICKS(5), .GLITCH_CYC(3)) DUT2 (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_button_n(button_n), .i_shutdown_req_n(req_n),
      .i_off_debounce_extension(off_ext), .i_shutdown_timeout_extension(kill_ext),
      .o_supply_en(en_b), .o_power_down_alert_n(alert_b));
   task results;
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wt(input logic v);
      n = 0;
      while (en !== v && n < 600)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(en, v)
   endtask
   task power_on;
      button_n = 0;
      wt(1);
      button_n = 1;
      repeat (60) @(negedge clk);
   endtask
   task wait_alert;
      button_n = 0;
      n = 0;
      while (alert_n !== 1'b0 && n < 600)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(alert_n, 1'b0)
   endtask
   task t_bounce;
      repeat (2)
      begin
         button_n = 0;
         repeat (8) @(negedge clk);
         button_n = 1;
         repeat (3) @(negedge clk);
      end
      repeat (20) @(negedge clk);
      `CHK(en, 1'b0)
   endtask
   task t_cycle;
      kill_ext = 16'h0004;
      power_on;
      `CHK(en, 1'b1)
      `CHK(en_b, 1'b0)
      wait_alert;
      `CHK(n >= 19 && n <= 22, 1'b1)
      `CHK(alert_n, 1'b0)
      `CHK(alert_b, 1'b0)
      wt(0);
      `CHK(n < 16, 1'b1)
      `CHK(en_b, 1'b1)
      @(negedge clk);
      `CHK(alert_n, 1'b1)
      repeat (24)
      begin
         @(negedge clk);
         `CHK(en, 1'b0)
      end
      button_n = 1;
   endtask
   task t_abort;
      hang_boot = 1;
      button_n = 0;
      wt(1);
      button_n = 1;
      wt(0);
      `CHK(n >= 28 && n <= 40, 1'b1)
      hang_boot = 0;
   endtask
   task t_kill;
      power_on;
      hang_boot = 1;
      repeat (2) @(negedge clk);
      hang_boot = 0;
      repeat (12) @(negedge clk);
      `CHK(en, 1'b1)
      hang_boot = 1;
      wt(0);
      `CHK(n < 16 && alert_n === 1'b1, 1'b1)
      hang_boot = 0;
   endtask
   task t_timeout;
      kill_ext = 16'h0002;
      off_ext = 16'h0000;
      hang_down = 1;
      power_on;
      wait_alert;
      `CHK(n >= 15 && n <= 18, 1'b1)
      wt(0);
      `CHK(n >= 20 && n <= 32, 1'b1)
      button_n = 1;
   endtask
   initial
   begin
      #2000000;
      fails++;
      results;
   end
   initial
   begin
      repeat (16) @(negedge clk);
      arst_n = 1;
      @(negedge clk);
      `CHK(en, 1'b0)
      t_bounce;
      t_cycle;
      repeat (40) @(negedge clk);
      t_abort;
      repeat (40) @(negedge clk);
      t_kill;
      repeat (40) @(negedge clk);
      t_timeout;
      results;
   end
endmodule // pbs_sequencer_tb
